// *** bench/gdf_fault_turnoff_tb.sv ***
// Purpose: Self-checking bench of the gate-driver fault block
// Assumes: Zero-wait APB, pins seen at most four edges after drive
// Notes: Random data from a fixed seed
`include "gdf_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module gdf_fault_turnoff_tb import gdf_pkg::*; ;
  localparam int PWM = 14, FSE = 13, FSL = 12, AI5 = 11, AI6 = 10, PTWN = 8;
  localparam int PTSD = 7, STWN = 6, STSD = 5, VCC1 = 4, OC = 2;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, trig = 1'b0, se, clamp_w;
  logic pready, pslverr, fault_alarm_n, warning_out_n;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv, d;
  logic [14:0] pv = 15'h0018;
  logic [29:0] ai_code = 30'h3FFF_FFFF;
  logic [2:0] bias_on;
  gdf_drive_t drive;
  gdf_pins_t pins_w;
  int err_total = 0, total_checks = 0, cyc = 0, seed = 32'hc170, k, n;
  assign pins_w = {pv[14:10], clamp_w, pv[8:0]};
  initial begin
    forever #20 pclk = ~pclk;
  end
  gdf_fault_turnoff u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins_w),
    .ai_code(ai_code), .drive(drive), .bias_on(bias_on),
    .fault_alarm_n(fault_alarm_n), .warning_out_n(warning_out_n));
  gdf_gate_model u_gate (.pclk(pclk), .presetn(presetn), .drive(drive),
    .trig(trig), .clamp_out(clamp_w));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setp(input int i, input logic v);
    @(posedge pclk);
    pv[i] <= v;
  endtask
  // Outputs are looked at mid-cycle, clear of edge updates
  task automatic hold(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask
  function automatic logic [31:0] msk(input int i);
    return i == 0 ? 32'h0000_FFFF : (i == 1 ? 32'h3FFF_FFFF : 32'h0000_0FFF);
  endfunction
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 15; k++) begin
      n = k % 3;
      d = $random(seed);
      if (k < 3) xfer(1'b0, 12'(n * 4), 32'h0000_0000);
      if (k < 3) chk("reset", 32'h0000_0000, rv);
      xfer(1'b1, 12'(n * 4), d);
      xfer(1'b0, 12'(n * 4), 32'h0000_0000);
      chk("rw", d & msk(n), rv);
    end
    xfer(1'b1, 12'h0F0, 32'hFFFF_FFFF);
    xfer(1'b0, 12'h0F0, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rv);
    chk("unmapped err", 32'h0000_0001, {31'h0, se});
    for (k = 0; k < 3; k++) xfer(1'b1, 12'(k * 4), 32'h0000_0000);
    d = $random(seed) & 32'h0000_0007;
    xfer(1'b1, `GDF_A_CTRL, {28'h0, d[2:0], 1'b1});
    hold(2);
    chk("bias", d, {29'h0, bias_on});
    xfer(1'b1, `GDF_A_CTRL, {28'h0, d[2:0], 1'b0});
    hold(2);
    chk("bias off", 32'h0000_0000, {29'h0, bias_on});
    $display("registers and bias done");
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8000);
    setp(PWM, 1'b1);
    for (k = 0; k < 2; k++) begin
      setp(FSL, k[0]);
      setp(FSE, 1'b1);
      hold(4);
      chk("pri forced", k, {31'h0, drive.gate_hi});
    end
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8500);
    setp(AI5, 1'b1);
    setp(VCC1, 1'b0);
    hold(4);
    chk("sec forced", 32'h0000_0000, {31'h0, drive.gate_hi});
    xfer(1'b0, `GDF_A_STAT, 32'h0000_0000);
    chk("mismatch flag", 32'h0000_0001, {31'h0, rv[5]});
    setp(AI5, 1'b0);
    hold(4);
    chk("pri unpowered", 32'h0000_0001, {31'h0, drive.gate_hi});
    setp(VCC1, 1'b1);
    setp(FSE, 1'b0);
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8020);
    xfer(1'b1, `GDF_A_CFG1, 32'h0000_0200);
    xfer(1'b1, `GDF_A_STAT, 32'h0000_007F);
    @(posedge pclk);
    ai_code[9:0] <= 10'h100;
    hold(40);
    chk("no monitor", 32'h0000_0001, {31'h0, fault_alarm_n});
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8030);
    hold(`GDF_DGL0_CYC - 5);
    chk("deglitch", 32'h0000_0001, {31'h0, fault_alarm_n});
    hold(10);
    chk("ot alarm", 32'h0000_0000, {31'h0, fault_alarm_n});
    chk("ot safe", 32'h0000_0000, {31'h0, drive.gate_hi});
    @(posedge pclk);
    ai_code <= 30'h3FFF_FFFF;
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8000);
    xfer(1'b1, `GDF_A_STAT, 32'h0000_007F);
    xfer(1'b1, `GDF_A_CFG2, 32'h0000_0002);
    $display("forced and overtemp done");
    // Third pass finishes the plateau with the soft current
    for (k = 0; k < 3; k++) begin
      if (k == 2) xfer(1'b1, `GDF_A_CTRL, 32'h0000_C000);
      xfer(1'b1, `GDF_A_CFG1, k == 2 ? 32'h14D8_0400 : (k ? 32'h14C0_0400 : 32'h0018_4000));
      hold(4);
      setp(OC, 1'b1);
      hold(4);
      chk("style sink", k ? 3 : 6, {28'h0, drive.sink_cur});
      chk("style plat", k != 0, {31'h0, drive.plat_act});
      chk("sink on", 32'h0000_0001, {31'h0, drive.sink_on});
      if (k) chk("plat lvl", 32'h0000_0005, {28'h0, drive.plat_lvl});
      xfer(1'b0, `GDF_A_STAT, 32'h0000_0000);
      chk("style state", k ? 2 : 1, {29'h0, rv[10:8]});
      if (k) hold(2 * `GDF_PLT_CYC + 5);
      if (k) chk("plat end", k == 2 ? 32'h0000_0006 : `GDF_SINK_FULL, {28'h0, drive.sink_cur});
      setp(OC, 1'b0);
    end
    xfer(1'b1, `GDF_A_CFG1, 32'h0018_0000);
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8200);
    trig <= 1'b1;
    setp(PWM, 1'b0);
    hold(14);
    chk("clamp sink", 32'h0000_0006, {28'h0, drive.sink_cur});
    xfer(1'b0, `GDF_A_STAT, 32'h0000_0000);
    chk("clamp flag", 32'h0000_0001, {31'h0, rv[1]});
    hold(`GDF_HLD_CYC + 10);
    chk("clamp end", `GDF_SINK_FULL, {28'h0, drive.sink_cur});
    setp(PWM, 1'b1);
    for (k = 0; k < 3; k++) begin
      n = k == 0 ? PTWN : (k == 1 ? STWN : STSD);
      setp(n, 1'b1);
      hold(4);
      chk("warn", k == 2, {31'h0, warning_out_n});
      chk("alarm", k != 2, {31'h0, fault_alarm_n});
      if (k == 2) chk("sec off", 32'h0000_0000, {31'h0, drive.gate_hi});
      xfer(1'b0, `GDF_A_STAT, 32'h0000_0000);
      chk("die flag", 32'h0000_0001, {31'h0, rv[k + 2]});
      setp(n, 1'b0);
      // Let the pin clear the synchroniser, or the set beats the clear
      hold(2);
      xfer(1'b1, `GDF_A_STAT, 32'h0000_007F);
    end
    setp(PTSD, 1'b1);
    hold(4);
    chk("pri reset", 32'h0000_0000, {31'h0, drive.gate_hi});
    xfer(1'b0, `GDF_A_CTRL, 32'h0000_0000);
    chk("pri regs", 32'h0000_0000, rv);
    setp(PTSD, 1'b0);
    // Synced shutdown still resets the registers for two edges
    hold(2);
    xfer(1'b1, `GDF_A_CTRL, 32'h0000_8000);
    hold(4);
    chk("reconfig", 32'h0000_0001, {31'h0, drive.gate_hi});
    $display("turn-off and die temperature done");
    complete_run();
  end
endmodule
`default_nettype wire

// *** bench/gdf_gate_model.sv ***
// Purpose: Gate and clamp-sense network at the driver output
// Assumes: Sense rises a few cycles after a commanded turn-off
// Notes: Overshoot only while the bench arms trig
`timescale 1ns/100ps
`default_nettype none
module gdf_gate_model
  import gdf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Driver side
  input wire gdf_drive_t drive,
  input wire logic trig,
  output logic clamp_out
);
  logic [3:0] cnt;
  logic gate_q;
  // Network charges only after the gate has fallen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      gate_q <= 1'b0;
    end else begin
      gate_q <= drive.gate_hi;
      if (gate_q && !drive.gate_hi && trig) begin
        cnt <= 4'h8;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  assign clamp_out = (cnt != 4'h0) && (cnt < 4'h6);
endmodule
`default_nettype wire

// *** rtl/gdf_defines.svh ***
// Purpose: Offsets, reset values and timing counts of the gate-driver fault block
// Assumes: 25 MHz pclk
// Notes: Times in ns, cycle counts derived from them
`ifndef GDF_DEFINES_SVH
`define GDF_DEFINES_SVH
`define GDF_A_CTRL 12'h000
`define GDF_A_CFG1 12'h004
`define GDF_A_CFG2 12'h008
`define GDF_A_STAT 12'h00C
`define GDF_CTRL_RST 32'h0000_0000
`define GDF_CFG1_RST 32'h0000_0000
`define GDF_CFG2_RST 32'h0000_0000
`define GDF_SINK_FULL 4'hF
`define GDF_CLK_NS 40
`define GDF_CYC_UP(t) (((t) + `GDF_CLK_NS - 1) / `GDF_CLK_NS)
`define GDF_DGL0_NS 1000
`define GDF_DGL1_NS 2000
`define GDF_DGL2_NS 4000
`define GDF_DGL3_NS 8000
`define GDF_DGL0_CYC `GDF_CYC_UP(`GDF_DGL0_NS)
`define GDF_DGL1_CYC `GDF_CYC_UP(`GDF_DGL1_NS)
`define GDF_DGL2_CYC `GDF_CYC_UP(`GDF_DGL2_NS)
`define GDF_DGL3_CYC `GDF_CYC_UP(`GDF_DGL3_NS)
`define GDF_HLD_NS 2000
`define GDF_HLD_CYC `GDF_CYC_UP(`GDF_HLD_NS)
`define GDF_PLT_UNIT_NS 1000
`define GDF_PLT_CYC `GDF_CYC_UP(`GDF_PLT_UNIT_NS)
`endif

// *** rtl/gdf_fault_turnoff.sv ***
// Purpose: Fault response and turn-off sequencing of an isolated gate driver
// Assumes: Pin inputs asynchronous, ADC codes on pclk, APB slave
// Notes: Fault classes index {desat, overtemp, short, overcurrent}
// Behaviour
// - Bias only with master enable, selected inputs
// - Overtemp sets flag, alarm, safe state
// - Overtemp turn-off style per select field
// - Overtemp registers after selected deglitch time
// - Only enabled inputs, only with monitor enable
// - Clamp trigger drops sink to soft current
// - Clamp hold time and clamp flag
// - Two-level turn-off only for enabled faults
// - Plateau discharge, hold duration, then off
// - Finish soft or hard per enable
// - Soft turn-off uses soft current setting
// - Soft turn-off only for enabled faults
// - Primary warning flag and warning output
// - Primary overtemp resets, holds output low without a forced request
// - Secondary warning flag and warning output
// - Secondary shutdown disables, alarms even unlatched
// - Forced enable drives forced level, ignores PWM
// - Forced mux repurposes fifth, sixth inputs
// - Secondary forced mismatch flags, no action
// - Secondary forced request wins over primary
// - Forced requests honoured whenever supplies valid
`include "gdf_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module gdf_fault_turnoff
  import gdf_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and sensing
  input wire gdf_pins_t pins,
  input wire logic [29:0] ai_code,
  // Driver side
  output gdf_drive_t drive,
  output logic [2:0] bias_on,
  output logic fault_alarm_n,
  output logic warning_out_n
);
  function automatic logic [2:0] dec(input logic [11:0] a);
    case (a)
      `GDF_A_CTRL: dec = 3'h4;
      `GDF_A_CFG1: dec = 3'h5;
      `GDF_A_CFG2: dec = 3'h6;
      `GDF_A_STAT: dec = 3'h7;
      default: dec = 3'h0;
    endcase
  endfunction

  gdf_pins_t s1;
  gdf_pins_t s;
  gdf_ctrl_t ctrl;
  gdf_cfg1_t cfg1;
  gdf_cfg2_t cfg2;
  gdf_st_t st;
  gdf_st_t next_st;
  logic [6:0] stat;
  logic [7:0] dgl_cnt;
  logic [12:0] plat_cnt;
  logic [7:0] hld_cnt;
  logic clamp_q;

  // Two-flop synchroniser; only s is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s <= '0;
    end else begin
      s1 <= pins;
      s <= s1;
    end
  end

  // Bus decode
  wire [2:0] d = dec(paddr);
  wire hit = d[2];
  wire [1:0] idx = d[1:0];
  wire acc = psel & penable;
  wire wr = acc & pwrite & hit;
  wire setup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  wire [31:0] stat_word = {21'h00_0000, st, 1'b0, stat};
  wire [31:0] rd_mux = ~hit ? 32'h0000_0000 :
                       idx == 2'h0 ? ctrl :
                       idx == 2'h1 ? cfg1 :
                       idx == 2'h2 ? cfg2 : stat_word;

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // Primary die overtemp returns configuration to reset state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `GDF_CTRL_RST;
      cfg1 <= `GDF_CFG1_RST;
      cfg2 <= `GDF_CFG2_RST;
    end else if (s.ptsd) begin
      ctrl <= `GDF_CTRL_RST;
      cfg1 <= `GDF_CFG1_RST;
      cfg2 <= `GDF_CFG2_RST;
    end else if (wr && idx == 2'h0) begin
      ctrl <= {16'h0000, pwdata[15:0]};
    end else if (wr && idx == 2'h1) begin
      cfg1 <= {2'h0, pwdata[29:0]};
    end else if (wr && idx == 2'h2) begin
      cfg2 <= {20'h0_0000, pwdata[11:0]};
    end
  end

  // Fifth input lost to temperature use in forced mode
  wire [2:0] ai_avail = {~ctrl.mux_forced, 2'h3};
  wire [2:0] in_ok = ctrl.ot_en & ai_avail & {3{ctrl.mon_en}};
  wire [2:0] below;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      assign below[gi] = in_ok[gi] & (ai_code[gi*10 +: 10] < cfg1.thr);
    end
  endgenerate
  wire ot_cond = |below;

  wire [7:0] dgl_lim = ctrl.dgl == 2'h0 ? 8'(`GDF_DGL0_CYC) :
                       ctrl.dgl == 2'h1 ? 8'(`GDF_DGL1_CYC) :
                       ctrl.dgl == 2'h2 ? 8'(`GDF_DGL2_CYC) : 8'(`GDF_DGL3_CYC);
  wire ot_hit = ot_cond & (dgl_cnt == dgl_lim - 8'h01);

  // Counter saturates so a lasting fault keeps re-setting the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dgl_cnt <= 8'h00;
    end else if (!ot_cond) begin
      dgl_cnt <= 8'h00;
    end else if (!ot_hit) begin
      dgl_cnt <= dgl_cnt + 8'h01;
    end
  end

  // Forced-state arbitration
  wire sec_act = ctrl.mux_forced & s.ai5 & s.vcc2;
  wire pri_act = s.fse & s.vcc1 & s.vcc2;
  wire ot_act = stat[0] & ~cfg2.mask[0];
  wire disabled = ~ctrl.drv_en | s.stsd | s.ptsd;
  wire [3:0] flt_vec = {s.desat, ot_act & ~ctrl.safe_hi, s.sc, s.oc};
  wire any_off = |flt_vec;
  wire cmd_on = ~disabled & ~any_off & (ot_act ? ctrl.safe_hi : s.pwm);
  wire gate_req = sec_act ? s.ai6 : (pri_act ? s.fsl : cmd_on);
  wire gm_set = ctrl.gm_en & sec_act & (s.ai6 != s.pwm);

  // Turn-off style selection
  wire flt_go = drive.gate_hi & ~gate_req & any_off & ~disabled;
  wire tlo = |(flt_vec & cfg1.tlo_sel);
  wire soft_turnoff = |(flt_vec & cfg1.sto_sel);
  wire [12:0] plat_lim = 13'(cfg2.dur * `GDF_PLT_CYC);
  wire plat_done = (plat_cnt + 13'h0001) >= plat_lim;

  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (flt_go && tlo) begin
          next_st = ST_PLAT;
        end else if (flt_go && soft_turnoff) begin
          next_st = ST_STO;
        end
      end
      ST_PLAT: begin
        if (gate_req) begin
          next_st = ST_IDLE;
        end else if (plat_done) begin
          next_st = ctrl.soft_fin ? ST_FINS : ST_FINH;
        end
      end
      ST_STO, ST_FINS: begin
        if (gate_req || !any_off) begin
          next_st = ST_IDLE;
        end
      end
      ST_FINH: next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_IDLE;
      plat_cnt <= 13'h0000;
    end else begin
      st <= next_st;
      plat_cnt <= (st == ST_PLAT) ? plat_cnt + 13'h0001 : 13'h0000;
    end
  end

  // Clamp sense: hold reduced sink for a fixed time after trigger
  wire clamp_act = hld_cnt != 8'h00;
  wire clamp_hit = ctrl.clamp_en & ~drive.gate_hi & s.clamp & ~clamp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hld_cnt <= 8'h00;
      clamp_q <= 1'b0;
    end else begin
      clamp_q <= s.clamp;
      if (clamp_hit) begin
        hld_cnt <= 8'(`GDF_HLD_CYC);
      end else if (clamp_act) begin
        hld_cnt <= hld_cnt - 8'h01;
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  wire [6:0] st_set = {s.ptsd, gm_set, s.stsd, s.stwn, s.ptwn, clamp_hit, ot_hit};
  wire [6:0] st_clr = (wr && idx == 2'h3) ? pwdata[6:0] : 7'h00;
  wire [6:0] next_stat = (stat & ~st_clr) | st_set;

  wire soft_sink = (next_st == ST_STO) | (next_st == ST_FINS) | clamp_act;
  wire [3:0] next_cur = (next_st == ST_PLAT) ? cfg1.plat_cur :
                        soft_sink ? cfg1.sto_cur : `GDF_SINK_FULL;
  wire alarm = ot_act | ((s.stsd | stat[4]) & ~cfg2.mask[3]);
  wire warn = (stat[2] & ~cfg2.mask[1]) | (stat[3] & ~cfg2.mask[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= 7'h00;
      drive <= '0;
      bias_on <= 3'h0;
      fault_alarm_n <= 1'b1;
      warning_out_n <= 1'b1;
    end else begin
      stat <= next_stat;
      drive.gate_hi <= gate_req;
      drive.sink_on <= ~gate_req;
      drive.sink_cur <= next_cur;
      drive.plat_lvl <= cfg1.plat_lvl;
      drive.plat_act <= next_st == ST_PLAT;
      bias_on <= {3{ctrl.bias_en}} & ctrl.bias_sel & ai_avail;
      fault_alarm_n <= ~alarm;
      warning_out_n <= ~warn;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_plat_enter;
    st == ST_IDLE && flt_go && tlo ##1 st == ST_PLAT;
  endsequence
  sequence seq_plat_exit;
    st == ST_PLAT && plat_done && !gate_req;
  endsequence

  bias_gate_a: assert property (!ctrl.bias_en |=> bias_on == 3'h0)
    else $error("bias current on without master enable");
  ot_deglitch_a: assert property ($rose(stat[0]) |-> $past(dgl_cnt) == $past(dgl_lim) - 8'h01)
    else $error("overtemp flag set before deglitch time");
  ot_flag_a: assert property (ot_hit && !ctrl.mux_forced |=> stat[0])
    else $error("overtemp flag not set");
  plat_cur_a: assert property (seq_plat_enter |-> drive.sink_cur == $past(cfg1.plat_cur))
    else $error("plateau current not applied");
  plat_fin_a: assert property (seq_plat_exit |=> st == ($past(ctrl.soft_fin) ? ST_FINS : ST_FINH))
    else $error("wrong plateau finish");
  sto_cur_a: assert property (st == ST_STO && $stable(cfg1) |-> drive.sink_cur == cfg1.sto_cur)
    else $error("soft turn-off current wrong");
  clamp_hold_a: assert property (clamp_hit |=> stat[1] && hld_cnt == 8'(`GDF_HLD_CYC))
    else $error("clamp hold not started");
  tsd_alarm_a: assert property (s.stsd && !cfg2.mask[3] |=> !fault_alarm_n)
    else $error("alarm missing on secondary shutdown");
  sec_prio_a: assert property (sec_act && pri_act |=> drive.gate_hi == $past(s.ai6))
    else $error("secondary forced request lost priority");
  forced_lvl_a: assert property (pri_act && !sec_act |=> drive.gate_hi == $past(s.fsl))
    else $error("forced level not driven");
  ptsd_low_a: assert property (s.ptsd && !sec_act && !pri_act |=> !drive.gate_hi ##1 !ctrl.drv_en)
    else $error("primary overtemp did not hold output low");
  gm_flag_a: assert property (gm_set |=> stat[5])
    else $error("gate monitor mismatch not flagged");

endmodule
`default_nettype wire

// *** rtl/gdf_pkg.sv ***
// Purpose: Types of the gate-driver fault block
// Assumes: Offsets and counts live in gdf_defines.svh
// Notes: Register structs give the field layout
package gdf_pkg;
  typedef struct packed {
    logic [15:0] rsv;
    logic drv_en;
    logic soft_fin;
    logic [1:0] dgl;
    logic safe_hi;
    logic gm_en;
    logic clamp_en;
    logic mux_forced;
    logic [2:0] ot_en;
    logic mon_en;
    logic [2:0] bias_sel;
    logic bias_en;
  } gdf_ctrl_t;
  typedef struct packed {
    logic [1:0] rsv;
    logic [3:0] plat_lvl;
    logic [3:0] plat_cur;
    logic [3:0] sto_cur;
    logic [3:0] sto_sel;
    logic [3:0] tlo_sel;
    logic [9:0] thr;
  } gdf_cfg1_t;
  typedef struct packed {
    logic [19:0] rsv;
    logic [3:0] mask;
    logic [7:0] dur;
  } gdf_cfg2_t;
  typedef struct packed {
    logic pwm;
    logic fse;
    logic fsl;
    logic ai5;
    logic ai6;
    logic clamp;
    logic ptwn;
    logic ptsd;
    logic stwn;
    logic stsd;
    logic vcc1;
    logic vcc2;
    logic oc;
    logic sc;
    logic desat;
  } gdf_pins_t;
  typedef struct packed {
    logic gate_hi;
    logic sink_on;
    logic [3:0] sink_cur;
    logic [3:0] plat_lvl;
    logic plat_act;
  } gdf_drive_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STO = 3'b001,
    ST_PLAT = 3'b010,
    ST_FINS = 3'b011,
    ST_FINH = 3'b100
  } gdf_st_t;
endpackage
